// [hw/cgm_pkg.sv]
package cgm_pkg;
    // Byte offsets
    localparam logic [4:0] CGM_OFF_CTL_ONE = 5'h00;
    localparam logic [4:0] CGM_OFF_CTL_TWO = 5'h04;
    localparam logic [4:0] CGM_OFF_STAT_ONE = 5'h08;
    localparam logic [4:0] CGM_OFF_STAT_TWO = 5'h0c;
    localparam logic [4:0] CGM_OFF_FILT_UP = 5'h10;
    localparam logic [4:0] CGM_OFF_FILT_LO = 5'h14;
    localparam logic [4:0] CGM_OFF_TRIM = 5'h18;

    // Control one fields
    localparam int CGM_C1_GAIN = 7;
    localparam int CGM_C1_RANGE = 6;
    localparam int CGM_C1_REFERENCE_TYPE_SELECT = 5;
    localparam int CGM_C1_SCHEME_HI = 4;
    localparam int CGM_C1_SCHEME_LO = 3;
    localparam int CGM_C1_STOPEN = 2;
    localparam int CGM_C1_CLOCK_LOSS_DETECT_DISABLE = 1;
    // Control two fields
    localparam int CGM_C2_UNLOCK_RE = 7;
    localparam int CGM_C2_MULT_HI = 6;
    localparam int CGM_C2_MULT_LO = 4;
    localparam int CGM_C2_LOSS_RE = 3;
    localparam int CGM_C2_RED_HI = 2;
    localparam int CGM_C2_RED_LO = 0;
    // Status one fields
    localparam int CGM_S1_FLAG = 0;

    // Reset values
    localparam logic [7:0] CGM_RST_CTL_ONE = 8'h00;
    localparam logic [7:0] CGM_RST_CTL_TWO = 8'h00;
    localparam logic [11:0] CGM_RST_FILT = 12'h000;
    localparam logic [7:0] CGM_RST_TRIM = 8'h80;

    // Frequency factors
    localparam logic [31:0] CGM_IRG_DIV = 32'h0000_0007;
    localparam logic [31:0] CGM_PRESCALE_LOW = 32'h0000_0040;
    localparam logic [31:0] CGM_PRESCALE_HIGH = 32'h0000_0001;

    // Timing
    localparam int CGM_CLK_MHZ = 40;
    localparam int CGM_LOCK_TIME_US = 100;
    localparam int CGM_LOCK_CYCLES = (CGM_LOCK_TIME_US * CGM_CLK_MHZ);
    localparam int CGM_SWITCH_CYCLES = 4;

    typedef enum logic [1:0] {
        CGM_SELF = 2'b00,
        CGM_ENG_INT = 2'b01,
        CGM_BYP_EXT = 2'b10,
        CGM_ENG_EXT = 2'b11
    } cgm_scheme_t;

    typedef enum logic [1:0] {
        CGM_SW_IDLE = 2'b00,
        CGM_SW_WAIT = 2'b01
    } cgm_sw_state_t;
endpackage

// [hw/cgm_clock_generator.sv]
// Implementation choices: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ps
// What this block does
// RQ1 - Self-clocked: oscillator over R.
// RQ2 - Bypassed external: external over R.
// RQ3 - Engaged internal: reference/7*64*N/R.
// RQ4 - Engaged external: external*P*N/R.
// RQ5 - N = 4 + 2 * multiply code.
// RQ6 - R = 2 ** reduce code.
// RQ7 - Reset: self-clocked, 8 MHz out, 4 MHz bus.
// RQ8 - Control one field layout; bit 0 reads zero.
// RQ9 - Scheme 11: engaged, external reference.
// RQ10 - Range 1: prescale 1; range 0: prescale 64.
// RQ11 - Reference 1 requests crystal; gain 0 is low power.
// RQ12 - Stop enable and loss-detect disable outputs.
// RQ13 - Control two: unlock reset enable, codes; enable 0 interrupts.
// RQ14 - Loss reset enable at bit 3; 0 interrupts.
// RQ15 - Status one field layout; writes only clear.
// RQ16 - Status two: oscillator stable in bit 0.
// RQ17 - Loop filter: 12 bits over two registers.
// RQ18 - Trim written only to trim internal reference.
// RQ19 - Software polls lock after setup.
// RQ20 - Scheme 01: engaged, internal reference.
// RQ21 - Scheme status lags a scheme write.
// RQ22 - Range takes only the first write.
// RQ23 - Flag and request stay until software clears.
// RQ24 - Code changes apply after relock; lock clears meanwhile.
module cgm_clock_generator
    import cgm_pkg::*;
#(
    parameter logic [31:0] DCO_KHZ = 32'd8000,
    parameter logic [31:0] EXT_KHZ = 32'd32,
    parameter logic [31:0] IRG_KHZ = 32'd243,
    parameter int LOCK_CYCLES = CGM_LOCK_CYCLES
) (
    input wire logic i_clk,
    input wire logic i_arst_n,
    input wire logic [4:0] i_s_axi_awaddr,
    input wire logic i_s_axi_awvalid,
    output logic o_s_axi_awready,
    input wire logic [31:0] i_s_axi_wdata,
    input wire logic [3:0] i_s_axi_wstrb,
    input wire logic i_s_axi_wvalid,
    output logic o_s_axi_wready,
    output logic [1:0] o_s_axi_bresp,
    output logic o_s_axi_bvalid,
    input wire logic i_s_axi_bready,
    input wire logic [4:0] i_s_axi_araddr,
    input wire logic i_s_axi_arvalid,
    output logic o_s_axi_arready,
    output logic [31:0] o_s_axi_rdata,
    output logic [1:0] o_s_axi_rresp,
    output logic o_s_axi_rvalid,
    input wire logic i_s_axi_rready,
    input wire logic i_ext_ref_ok,
    input wire logic i_osc_stable,
    input wire logic i_clock_loss,
    input wire logic i_lock_lost,
    output logic [31:0] o_out_freq_khz,
    output logic [31:0] o_bus_freq_khz,
    output logic [1:0] o_scheme,
    output logic o_lock,
    output logic o_irq,
    output logic o_reset_req,
    output logic o_gain_high,
    output logic o_range_high,
    output logic o_crystal_req,
    output logic o_stop_osc_en,
    output logic o_loss_detect_en,
    output logic [11:0] o_filter,
    output logic [7:0] o_trim
);
    localparam int NSYNC = 4;
    localparam int LCW = $clog2(LOCK_CYCLES + 1);
    localparam logic [LCW-1:0] LOCK_LAST = LCW'(LOCK_CYCLES - 1);

    // Three-stage pin sync
    logic [NSYNC-1:0] pin_in;
    logic [NSYNC-1:0] s1_r, s2_r, s3_r, filt_r;
    assign pin_in = {i_lock_lost, i_clock_loss, i_osc_stable, i_ext_ref_ok};
    genvar g;
    generate
        for (g = 0; g < NSYNC; g++) begin : g_sync
            always_ff @(posedge i_clk or negedge i_arst_n) begin
                if (!i_arst_n) begin
                    s1_r[g] <= 1'b0;
                    s2_r[g] <= 1'b0;
                    s3_r[g] <= 1'b0;
                    filt_r[g] <= 1'b0;
                end else begin
                    s1_r[g] <= pin_in[g];
                    s2_r[g] <= s1_r[g];
                    s3_r[g] <= s2_r[g];
                    if (s2_r[g] == s3_r[g]) begin
                        filt_r[g] <= s3_r[g];
                    end
                end
            end
        end
    endgenerate
    logic ext_ok, osc_ok, loss_lvl, lost_lvl, loss_d_r, lost_d_r;
    assign ext_ok = filt_r[0];
    assign osc_ok = filt_r[1];
    assign loss_lvl = filt_r[2];
    assign lost_lvl = filt_r[3];

    // Write path; address and data in either order
    logic aw_full_r, w_full_r;
    logic [4:0] aw_addr_r;
    logic [7:0] w_byte_r;
    logic w_lane_r;
    logic wr_go;
    logic wr_hit;
    assign wr_go = aw_full_r && w_full_r && !o_s_axi_bvalid;
    always_comb begin
        case (aw_addr_r)
            CGM_OFF_CTL_ONE, CGM_OFF_CTL_TWO, CGM_OFF_STAT_ONE, CGM_OFF_STAT_TWO,
            CGM_OFF_FILT_UP, CGM_OFF_FILT_LO, CGM_OFF_TRIM: wr_hit = 1'b1;
            default: wr_hit = 1'b0;
        endcase
    end
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            aw_full_r <= 1'b0;
            w_full_r <= 1'b0;
            aw_addr_r <= 5'h00;
            w_byte_r <= 8'h00;
            w_lane_r <= 1'b0;
            o_s_axi_awready <= 1'b0;
            o_s_axi_wready <= 1'b0;
            o_s_axi_bvalid <= 1'b0;
            o_s_axi_bresp <= 2'b00;
        end else begin
            o_s_axi_awready <= !aw_full_r && !(o_s_axi_awready && i_s_axi_awvalid);
            o_s_axi_wready <= !w_full_r && !(o_s_axi_wready && i_s_axi_wvalid);
            if (o_s_axi_awready && i_s_axi_awvalid) begin
                aw_full_r <= 1'b1;
                aw_addr_r <= {i_s_axi_awaddr[4:2], 2'b00};
            end
            if (o_s_axi_wready && i_s_axi_wvalid) begin
                w_full_r <= 1'b1;
                w_byte_r <= i_s_axi_wdata[7:0];
                w_lane_r <= i_s_axi_wstrb[0];
            end
            if (wr_go) begin
                aw_full_r <= 1'b0;
                w_full_r <= 1'b0;
                o_s_axi_bvalid <= 1'b1;
                o_s_axi_bresp <= wr_hit ? 2'b00 : 2'b10;
            end else if (o_s_axi_bvalid && i_s_axi_bready) begin
                o_s_axi_bvalid <= 1'b0;
            end
        end
    end
    logic wr_en;
    assign wr_en = wr_go && w_lane_r;

    // Control registers
    logic [7:0] ctl_one_r, ctl_two_r;
    logic range_done_r, reference_type_select_done_r;
    logic [11:0] filt_val_r;
    logic [7:0] trim_r;
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            ctl_one_r <= CGM_RST_CTL_ONE; // RQ7
            range_done_r <= 1'b0;
            reference_type_select_done_r <= 1'b0;
        end else if (wr_en && aw_addr_r == CGM_OFF_CTL_ONE) begin
            ctl_one_r[CGM_C1_GAIN] <= w_byte_r[CGM_C1_GAIN]; // RQ8 RQ11
            ctl_one_r[CGM_C1_SCHEME_HI:CGM_C1_SCHEME_LO] <= w_byte_r[CGM_C1_SCHEME_HI:CGM_C1_SCHEME_LO]; // RQ8
            ctl_one_r[CGM_C1_STOPEN] <= w_byte_r[CGM_C1_STOPEN]; // RQ12
            ctl_one_r[CGM_C1_CLOCK_LOSS_DETECT_DISABLE] <= w_byte_r[CGM_C1_CLOCK_LOSS_DETECT_DISABLE]; // RQ12
            ctl_one_r[0] <= 1'b0; // RQ8
            range_done_r <= 1'b1;
            reference_type_select_done_r <= 1'b1;
            if (!range_done_r) begin
                ctl_one_r[CGM_C1_RANGE] <= w_byte_r[CGM_C1_RANGE]; // RQ22
            end
            if (!reference_type_select_done_r) begin
                ctl_one_r[CGM_C1_REFERENCE_TYPE_SELECT] <= w_byte_r[CGM_C1_REFERENCE_TYPE_SELECT];
            end
        end
    end
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            ctl_two_r <= CGM_RST_CTL_TWO;
        end else if (wr_en && aw_addr_r == CGM_OFF_CTL_TWO) begin
            ctl_two_r <= w_byte_r; // RQ13 RQ14
        end
    end
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            filt_val_r <= CGM_RST_FILT;
            trim_r <= CGM_RST_TRIM;
        end else if (wr_en) begin
            if (aw_addr_r == CGM_OFF_FILT_UP) begin
                filt_val_r[11:8] <= w_byte_r[3:0]; // RQ17
            end
            if (aw_addr_r == CGM_OFF_FILT_LO) begin
                filt_val_r[7:0] <= w_byte_r; // RQ17
            end
            if (aw_addr_r == CGM_OFF_TRIM) begin
                trim_r <= w_byte_r; // RQ18
            end
        end
    end

    // Scheme switch
    cgm_scheme_t want, stat_r;
    cgm_sw_state_t sw_r;
    logic [2:0] sw_cnt_r;
    logic want_ready;
    assign want = cgm_scheme_t'(ctl_one_r[CGM_C1_SCHEME_HI:CGM_C1_SCHEME_LO]);
    assign want_ready = (want == CGM_BYP_EXT || want == CGM_ENG_EXT) ? ext_ok : 1'b1;
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            stat_r <= CGM_SELF; // RQ7
            sw_r <= CGM_SW_IDLE;
            sw_cnt_r <= 3'h0;
        end else begin
            case (sw_r)
                CGM_SW_IDLE: begin
                    sw_cnt_r <= 3'h0;
                    if (want != stat_r && want_ready) begin
                        sw_r <= CGM_SW_WAIT;
                    end
                end
                CGM_SW_WAIT: begin
                    if (want == stat_r || !want_ready) begin
                        sw_r <= CGM_SW_IDLE;
                    end else if (sw_cnt_r == 3'(CGM_SWITCH_CYCLES - 1)) begin
                        stat_r <= want; // RQ21 RQ9 RQ20
                        sw_r <= CGM_SW_IDLE;
                    end else begin
                        sw_cnt_r <= sw_cnt_r + 3'h1;
                    end
                end
                default: sw_r <= CGM_SW_IDLE;
            endcase
        end
    end

    // Retune or scheme change restarts locking
    logic engaged;
    logic [2:0] mult_used_r, red_used_r;
    logic [LCW-1:0] lock_cnt_r;
    logic lock_r;
    logic retune;
    logic lost_evt;
    assign engaged = (stat_r == CGM_ENG_INT) || (stat_r == CGM_ENG_EXT);
    assign lost_evt = lost_lvl && !lost_d_r && lock_r;
    assign retune = (ctl_two_r[CGM_C2_MULT_HI:CGM_C2_MULT_LO] != mult_used_r) ||
                    (ctl_two_r[CGM_C2_RED_HI:CGM_C2_RED_LO] != red_used_r);
    cgm_scheme_t lock_scheme_r;
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            lock_r <= 1'b0;
            lock_cnt_r <= '0;
            mult_used_r <= 3'h0;
            red_used_r <= 3'h0;
            lock_scheme_r <= CGM_SELF;
            lost_d_r <= 1'b0;
        end else begin
            lost_d_r <= lost_lvl;
            if (!engaged) begin
                lock_r <= 1'b0;
                lock_cnt_r <= '0;
                red_used_r <= ctl_two_r[CGM_C2_RED_HI:CGM_C2_RED_LO];
                lock_scheme_r <= stat_r;
            end else if (retune || lost_evt || lock_scheme_r != stat_r) begin
                lock_r <= 1'b0; // RQ24
                lock_cnt_r <= '0;
                lock_scheme_r <= stat_r;
                mult_used_r <= ctl_two_r[CGM_C2_MULT_HI:CGM_C2_MULT_LO];
                red_used_r <= ctl_two_r[CGM_C2_RED_HI:CGM_C2_RED_LO];
            end else if (!lock_r) begin
                if (lock_cnt_r == LOCK_LAST) begin
                    lock_r <= 1'b1; // RQ24
                end else begin
                    lock_cnt_r <= lock_cnt_r + 1'b1;
                end
            end
        end
    end

    // Engaged schemes retune only once locked
    function automatic logic [31:0] mult_n(input logic [2:0] code);
        mult_n = {28'h0, code, 1'b0} + 32'h0000_0004; // RQ5
    endfunction
    logic [31:0] prescale;
    logic [31:0] freq_nxt;
    assign prescale = ctl_one_r[CGM_C1_RANGE] ? CGM_PRESCALE_HIGH : CGM_PRESCALE_LOW; // RQ10 RQ4
    always_comb begin
        freq_nxt = o_out_freq_khz;
        case (stat_r)
            CGM_SELF: freq_nxt = DCO_KHZ >> red_used_r; // RQ1 RQ6
            CGM_BYP_EXT: freq_nxt = EXT_KHZ >> red_used_r; // RQ2
            CGM_ENG_INT: begin
                if (lock_r) begin
                    freq_nxt = ((IRG_KHZ * CGM_PRESCALE_LOW * mult_n(mult_used_r)) / CGM_IRG_DIV) >> red_used_r; // RQ3
                end
            end
            CGM_ENG_EXT: begin
                if (lock_r) begin
                    freq_nxt = (EXT_KHZ * prescale * mult_n(mult_used_r)) >> red_used_r; // RQ4
                end
            end
            default: freq_nxt = o_out_freq_khz;
        endcase
    end
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_out_freq_khz <= DCO_KHZ; // RQ7
            o_bus_freq_khz <= DCO_KHZ >> 1;
        end else begin
            o_out_freq_khz <= freq_nxt;
            o_bus_freq_khz <= freq_nxt >> 1;
        end
    end

    // Sticky status and flag; set wins over clear
    logic ext_in_use;
    logic loss_evt;
    logic unlock_st_r, loss_st_r, flag_r;
    logic st_clr;
    assign ext_in_use = (stat_r == CGM_BYP_EXT) || (stat_r == CGM_ENG_EXT);
    assign loss_evt = loss_lvl && !loss_d_r && ext_in_use && !ctl_one_r[CGM_C1_CLOCK_LOSS_DETECT_DISABLE]; // RQ12
    assign st_clr = wr_en && aw_addr_r == CGM_OFF_STAT_ONE && w_byte_r[CGM_S1_FLAG];
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            loss_d_r <= 1'b0;
            unlock_st_r <= 1'b0;
            loss_st_r <= 1'b0;
            flag_r <= 1'b0;
            o_reset_req <= 1'b0;
        end else begin
            loss_d_r <= loss_lvl;
            o_reset_req <= (lost_evt && ctl_two_r[CGM_C2_UNLOCK_RE]) ||
                           (loss_evt && ctl_two_r[CGM_C2_LOSS_RE]); // RQ13 RQ14
            if (lost_evt) begin
                unlock_st_r <= 1'b1;
            end else if (st_clr) begin
                unlock_st_r <= 1'b0;
            end
            if (loss_evt) begin
                loss_st_r <= 1'b1;
            end else if (st_clr) begin
                loss_st_r <= 1'b0;
            end
            if ((lost_evt && !ctl_two_r[CGM_C2_UNLOCK_RE]) || (loss_evt && !ctl_two_r[CGM_C2_LOSS_RE])) begin
                flag_r <= 1'b1; // RQ13 RQ14 RQ23
            end else if (st_clr) begin
                flag_r <= 1'b0; // RQ23
            end
        end
    end

    // Read path
    logic [7:0] rd_byte;
    logic rd_hit;
    logic [4:0] rd_addr;
    assign rd_addr = {i_s_axi_araddr[4:2], 2'b00};
    always_comb begin
        rd_hit = 1'b1;
        rd_byte = 8'h00;
        case (rd_addr)
            CGM_OFF_CTL_ONE: rd_byte = ctl_one_r;
            CGM_OFF_CTL_TWO: rd_byte = ctl_two_r;
            CGM_OFF_STAT_ONE: rd_byte = {stat_r, ctl_one_r[CGM_C1_REFERENCE_TYPE_SELECT], unlock_st_r, lock_r,
                                         loss_st_r, ext_ok, flag_r}; // RQ15
            CGM_OFF_STAT_TWO: rd_byte = {7'h00, osc_ok}; // RQ16
            CGM_OFF_FILT_UP: rd_byte = {4'h0, filt_val_r[11:8]}; // RQ17
            CGM_OFF_FILT_LO: rd_byte = filt_val_r[7:0];
            CGM_OFF_TRIM: rd_byte = trim_r;
            default: rd_hit = 1'b0;
        endcase
    end
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_s_axi_arready <= 1'b0;
            o_s_axi_rvalid <= 1'b0;
            o_s_axi_rdata <= 32'h0000_0000;
            o_s_axi_rresp <= 2'b00;
        end else begin
            o_s_axi_arready <= !o_s_axi_rvalid && !(o_s_axi_arready && i_s_axi_arvalid);
            if (o_s_axi_arready && i_s_axi_arvalid) begin
                o_s_axi_rvalid <= 1'b1;
                o_s_axi_rdata <= {24'h000000, rd_byte};
                o_s_axi_rresp <= rd_hit ? 2'b00 : 2'b10;
            end else if (o_s_axi_rvalid && i_s_axi_rready) begin
                o_s_axi_rvalid <= 1'b0;
            end
        end
    end

    // Registered configuration and status copies
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_scheme <= CGM_SELF;
            o_lock <= 1'b0;
            o_irq <= 1'b0;
            o_gain_high <= 1'b0;
            o_range_high <= 1'b0;
            o_crystal_req <= 1'b0;
            o_stop_osc_en <= 1'b0;
            o_loss_detect_en <= 1'b1;
            o_filter <= CGM_RST_FILT;
            o_trim <= CGM_RST_TRIM;
        end else begin
            o_scheme <= stat_r;
            o_lock <= lock_r; // RQ19
            o_irq <= flag_r; // RQ23
            o_gain_high <= ctl_one_r[CGM_C1_GAIN]; // RQ11
            o_range_high <= ctl_one_r[CGM_C1_RANGE]; // RQ10
            o_crystal_req <= ctl_one_r[CGM_C1_REFERENCE_TYPE_SELECT]; // RQ11
            o_stop_osc_en <= ctl_one_r[CGM_C1_STOPEN]; // RQ12
            o_loss_detect_en <= !ctl_one_r[CGM_C1_CLOCK_LOSS_DETECT_DISABLE]; // RQ12
            o_filter <= filt_val_r;
            o_trim <= trim_r;
        end
    end
endmodule

// [hw/cgm_unused_placeholder_none.sv]
`timescale 1ns/1ps

// [testbench/cgm_props.sv]
`timescale 1ns/1ps
module cgm_props (
    input wire logic i_clk,
    input wire logic i_arst_n,
    input wire logic i_s_axi_awvalid,
    input wire logic i_s_axi_wvalid,
    input wire logic i_s_axi_arvalid,
    input wire logic i_s_axi_rready,
    input wire logic i_s_axi_bready,
    input wire logic o_s_axi_wready,
    input wire logic o_s_axi_arready,
    input wire logic o_s_axi_bvalid,
    input wire logic [1:0] o_s_axi_bresp,
    input wire logic o_s_axi_rvalid,
    input wire logic [31:0] o_s_axi_rdata,
    input wire logic [31:0] o_out_freq_khz,
    input wire logic [31:0] o_bus_freq_khz,
    input wire logic [1:0] o_scheme,
    input wire logic o_irq,
    input wire logic o_reset_req
);
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_arst_n);
    sequence s_rd_taken;
        i_s_axi_arvalid && o_s_axi_arready;
    endsequence
    sequence s_wr_taken;
        i_s_axi_wvalid && o_s_axi_wready;
    endsequence
    sequence s_no_write;
        !i_s_axi_wvalid && !i_s_axi_awvalid;
    endsequence
    a_read_answer: assert property (s_rd_taken |=> o_s_axi_rvalid && !o_s_axi_arready)
        else $error("read answer missing");
    a_rdata_stands: assert property (o_s_axi_rvalid && !i_s_axi_rready |=> o_s_axi_rvalid && $stable(o_s_axi_rdata))
        else $error("read data dropped");
    a_bresp_stands: assert property (o_s_axi_bvalid && !i_s_axi_bready |=> o_s_axi_bvalid && $stable(o_s_axi_bresp))
        else $error("write response dropped");
    a_rdata_upper_zero: assert property (o_s_axi_rvalid |-> o_s_axi_rdata[31:8] == 24'h000000)
        else $error("read data upper bits set");
    a_bus_half: assert property (o_bus_freq_khz == (o_out_freq_khz >> 1) ||
        o_bus_freq_khz == ($past(o_out_freq_khz) >> 1)) else $error("bus clock not half");
    a_irq_sticky: assert property (s_no_write ##1 s_no_write ##1 s_no_write ##0 o_irq |=> o_irq)
        else $error("interrupt flag dropped without clear");
    a_scheme_deferred: assert property (s_wr_taken |=> $stable(o_scheme))
        else $error("scheme status changed at once");
    a_reset_pulse: assert property (o_reset_req |=> !o_reset_req)
        else $error("reset request longer than one cycle");
endmodule
bind cgm_clock_generator cgm_props u_props (.*);

// [testbench/cgm_ext_src.sv]
`timescale 1ns/1ps
module cgm_ext_src #(
    parameter int START_CYC = 6
) (
    input wire logic i_clk,
    input wire logic i_arst_n,
    input wire logic i_run,
    input wire logic i_fail,
    input wire logic i_slip,
    output logic o_ok,
    output logic o_stable,
    output logic o_loss,
    output logic o_lost
);
    int cnt_r;
    // Reference start-up delay
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n || !i_run) cnt_r <= 0;
        else if (cnt_r < START_CYC) cnt_r <= cnt_r + 1;
    end
    assign o_ok = i_run && cnt_r == START_CYC && !i_fail;
    assign o_stable = o_ok;
    assign o_loss = i_run && i_fail;
    assign o_lost = i_slip;
endmodule

// [testbench/testbench.sv]
`timescale 1ns/1ps
module testbench
    import cgm_pkg::*;
;
    logic i_clk, i_arst_n, i_s_axi_awvalid, i_s_axi_wvalid, i_s_axi_bready, i_s_axi_arvalid, i_s_axi_rready;
    logic [4:0] i_s_axi_awaddr, i_s_axi_araddr;
    logic [31:0] i_s_axi_wdata, o_s_axi_rdata, o_out_freq_khz, o_bus_freq_khz, d;
    logic [3:0] i_s_axi_wstrb;
    logic [1:0] o_s_axi_bresp, o_s_axi_rresp, o_scheme, r;
    logic o_s_axi_awready, o_s_axi_wready, o_s_axi_bvalid, o_s_axi_arready, o_s_axi_rvalid, o_lock, o_irq;
    logic o_reset_req, o_gain_high, o_range_high, o_crystal_req, o_stop_osc_en, o_loss_detect_en;
    logic i_ext_ref_ok, i_osc_stable, i_clock_loss, i_lock_lost, run, fail, slip;
    logic [11:0] o_filter;
    logic [7:0] o_trim;
    int error_cnt, checks_done, k;
    cgm_clock_generator #(.LOCK_CYCLES(8)) dut (.*);
    cgm_ext_src ext (.i_clk, .i_arst_n, .i_run(run), .i_fail(fail), .i_slip(slip),
        .o_ok(i_ext_ref_ok), .o_stable(i_osc_stable), .o_loss(i_clock_loss), .o_lost(i_lock_lost));
    task automatic test_done();
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic tmo();
        error_cnt++;
        $display("MISMATCH wait expected done seen timeout");
        test_done();
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge i_clk);
    endtask
    task automatic do_rst();
        @(posedge i_clk);
        i_arst_n <= 1'b0;
        cyc(2);
        i_arst_n <= 1'b1;
        @(posedge i_clk);
    endtask
    task automatic wr(input logic [4:0] a, input logic [7:0] v, input logic [1:0] er);
        int n;
        logic dn;
        dn = 1'b0;
        @(posedge i_clk);
        i_s_axi_awaddr <= a;
        i_s_axi_wdata <= {24'h000000, v};
        i_s_axi_awvalid <= 1'b1;
        i_s_axi_wvalid <= 1'b1;
        i_s_axi_bready <= 1'b1;
        for (n = 0; n < 40 && !dn; n++) begin
            @(posedge i_clk);
            if (i_s_axi_awvalid && o_s_axi_awready) i_s_axi_awvalid <= 1'b0;
            if (i_s_axi_wvalid && o_s_axi_wready) i_s_axi_wvalid <= 1'b0;
            if (o_s_axi_bvalid === 1'b1) begin
                dn = 1'b1;
                i_s_axi_bready <= 1'b0;
                chk("bresp", {30'h0, er}, {30'h0, o_s_axi_bresp});
            end
        end
        if (!dn) tmo();
    endtask
    task automatic rd(input logic [4:0] a, output logic [31:0] q, output logic [1:0] rr);
        int n;
        logic dn;
        dn = 1'b0;
        @(posedge i_clk);
        i_s_axi_araddr <= a;
        i_s_axi_arvalid <= 1'b1;
        i_s_axi_rready <= 1'b1;
        for (n = 0; n < 40 && !dn; n++) begin
            @(posedge i_clk);
            if (i_s_axi_arvalid && o_s_axi_arready) i_s_axi_arvalid <= 1'b0;
            if (o_s_axi_rvalid === 1'b1) begin
                dn = 1'b1;
                i_s_axi_rready <= 1'b0;
                q = o_s_axi_rdata;
                rr = o_s_axi_rresp;
            end
        end
        if (!dn) tmo();
    endtask
    task automatic rchk(input string nm, input logic [4:0] a, input logic [7:0] e, input logic [1:0] er);
        rd(a, d, r);
        chk(nm, {24'h000000, e}, d);
        chk("rresp", {30'h0, er}, {30'h0, r});
    endtask
    // Poll status one until masked bits match
    task automatic wait_st(input logic [7:0] m, input logic [7:0] v);
        int n;
        d = 32'h0;
        for (n = 0; n < 60 && (d[7:0] & m) !== v; n++) rd(CGM_OFF_STAT_ONE, d, r);
        if ((d[7:0] & m) !== v) tmo();
        cyc(2);
    endtask
    task automatic wait_ev(input bit rq);
        int n;
        for (n = 0; n < 30 && (rq ? o_reset_req : o_irq) !== 1'b1; n++) @(posedge i_clk);
        if ((rq ? o_reset_req : o_irq) !== 1'b1) tmo();
    endtask
    initial begin
        i_clk = 1'b0;
        forever #12.5 i_clk = ~i_clk;
    end
    initial begin
        {i_s_axi_awvalid, i_s_axi_wvalid, i_s_axi_bready, i_s_axi_arvalid, i_s_axi_rready} = 5'h00;
        {i_s_axi_awaddr, i_s_axi_araddr, i_s_axi_wdata} = 42'h0;
        i_s_axi_wstrb = 4'h1;
        {run, fail, slip, i_arst_n} = 4'h0;
        error_cnt = 0;
        checks_done = 0;
        do_rst();
        chk("out", 32'h1f40, o_out_freq_khz);
        chk("bus", 32'h0fa0, o_bus_freq_khz);
        chk("ldet", 32'h1, {31'h0, o_loss_detect_en});
        rchk("c1", CGM_OFF_CTL_ONE, 8'h00, 2'h0);
        rchk("c2", CGM_OFF_CTL_TWO, 8'h00, 2'h0);
        rchk("trim", CGM_OFF_TRIM, 8'h80, 2'h0);
        rchk("s2", CGM_OFF_STAT_TWO, 8'h00, 2'h0);
        rchk("bad", 5'h1c, 8'h00, 2'h2);
        wr(5'h1c, 8'hff, 2'h2);
        wr(CGM_OFF_FILT_UP, 8'hff, 2'h0);
        wr(CGM_OFF_FILT_LO, 8'h5a, 2'h0);
        wr(CGM_OFF_TRIM, 8'h55, 2'h0);
        rchk("fu", CGM_OFF_FILT_UP, 8'h0f, 2'h0);
        chk("flt", 32'h0f5a, {20'h0, o_filter});
        chk("trm", 32'h55, {24'h0, o_trim});
        for (k = 0; k < 8; k++) begin
            wr(CGM_OFF_CTL_TWO, 8'(k), 2'h0);
            cyc(2);
            chk("self", 32'h1f40 >> k, o_out_freq_khz);
        end
        run <= 1'b1;
        wr(CGM_OFF_CTL_ONE, 8'hbf, 2'h0);
        chk("sch", 32'h0, {30'h0, o_scheme});
        cyc(1);
        chk("c1bits", 32'h16, {27'h0, o_gain_high, o_range_high, o_crystal_req, o_stop_osc_en, o_loss_detect_en});
        rchk("c1", CGM_OFF_CTL_ONE, 8'hbe, 2'h0);
        wait_st(8'hc8, 8'hc8);
        rchk("s2", CGM_OFF_STAT_TWO, 8'h01, 2'h0);
        for (k = 0; k < 8; k++) begin
            wr(CGM_OFF_CTL_TWO, 8'(k << 4), 2'h0);
            cyc(2);
            chk("lock", 32'h0, {31'h0, o_lock});
            wait_st(8'h08, 8'h08);
            chk("eng", 32'h0800 * (4 + 2 * k), o_out_freq_khz);
        end
        wr(CGM_OFF_CTL_ONE, 8'h58, 2'h0);
        rchk("c1once", CGM_OFF_CTL_ONE, 8'h38, 2'h0);
        slip <= 1'b1;
        wait_ev(1'b0);
        slip <= 1'b0;
        cyc(6);
        chk("irq", 32'h1, {31'h0, o_irq});
        rd(CGM_OFF_STAT_ONE, d, r);
        chk("s1", 32'hd1, d & 32'hd1);
        wr(CGM_OFF_STAT_ONE, 8'h01, 2'h0);
        cyc(2);
        chk("irqclr", 32'h0, {31'h0, o_irq});
        wr(CGM_OFF_CTL_TWO, 8'hf0, 2'h0);
        wait_st(8'h08, 8'h08);
        slip <= 1'b1;
        wait_ev(1'b1);
        slip <= 1'b0;
        chk("irqrst", 32'h0, {31'h0, o_irq});
        wr(CGM_OFF_CTL_TWO, 8'h31, 2'h0);
        wr(CGM_OFF_CTL_ONE, 8'h28, 2'h0);
        wait_st(8'hc8, 8'h48);
        chk("int", (32'h00f3 * 32'h0040 * 32'h000a / 32'h0007) >> 1, o_out_freq_khz);
        wr(CGM_OFF_CTL_TWO, 8'h02, 2'h0);
        wr(CGM_OFF_CTL_ONE, 8'h30, 2'h0);
        wait_st(8'hc0, 8'h80);
        chk("byp", 32'h0008, o_out_freq_khz);
        fail <= 1'b1;
        wait_ev(1'b0);
        rd(CGM_OFF_STAT_ONE, d, r);
        chk("loss", 32'h05, d & 32'h05);
        fail <= 1'b0;
        do_rst();
        wr(CGM_OFF_CTL_TWO, 8'h30, 2'h0);
        wr(CGM_OFF_CTL_ONE, 8'h78, 2'h0);
        wait_st(8'hc8, 8'hc8);
        chk("hi", 32'h0140, o_out_freq_khz);
        chk("rng", 32'h1, {31'h0, o_range_high});
        test_done();
    end
endmodule
